// ===== inc/reset_source_pkg.sv
package reset_source_pkg;

	// register map: printed offsets are indexes, byte address is 4x
	localparam int          ADDR_W      = 12;
	localparam logic [7:0]  MON_INDEX   = 8'hFF;
	localparam logic [7:0]  SRC_INDEX   = 8'hEF;
	localparam logic [11:0] MON_ADDR    = {2'b00, MON_INDEX, 2'b00};
	localparam logic [11:0] SRC_ADDR    = {2'b00, SRC_INDEX, 2'b00};

	// supply monitor control fields
	localparam int          MON_EN_BIT  = 7;
	localparam int          MON_ST_BIT  = 6;
	localparam logic        MON_EN_RST  = 1'b1;

	// reset source fields, flag and control share positions
	localparam int          F_PIN       = 0;
	localparam int          F_PWR       = 1;
	localparam int          F_MCD       = 2;
	localparam int          F_WDT       = 3;
	localparam int          F_SW        = 4;
	localparam int          F_CMP       = 5;
	localparam int          F_MEM       = 6;
	localparam int          NCAUSE      = 7;
	localparam logic [6:0]  FLAGS_RST   = 7'h02;
	localparam logic [6:0]  NO_CAUSE    = 7'h00;

	// timing at the system clock rate
	localparam int          CLK_NS      = 8;
	localparam int          MCD_TMO_NS  = 500;
	localparam int          MCD_CYC     = (MCD_TMO_NS + CLK_NS - 1) / CLK_NS;
	localparam int          HOLD_NS     = 80;
	localparam int          HOLD_CYC    = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int          WD_DIV      = 12;
	localparam int          CNT_W       = 8;
	localparam logic [15:0] CODE_LIMIT  = 16'h3FFF;

	// sequencer states
	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_HOLD = 2'b10
	} state_t;

endpackage

// ===== hw/reset_source_controller.sv
// Our own choice: the APB interface to the registers.
module reset_source_controller #(
	parameter logic [15:0] CODE_LIMIT = reset_source_pkg::CODE_LIMIT
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rstPinN,
	output logic             rstPinOut,
	output logic             rstPinOe,
	input  wire logic        supplyLevel,
	input  wire logic        comparatorOut,
	input  wire logic        coreClkTick,
	input  wire logic        watchdogExpire,
	input  wire logic        watchdogStop,
	input  wire logic        codeAccess,
	input  wire logic [15:0] codeAddr,
	output logic             monitorOn,
	output logic             coreReset,
	output logic             watchdogEnable,
	output logic             watchdogTick
);

	// lowest set bit wins: pin, power, clock, watchdog, sw, comp, mem
	function automatic logic [6:0] firstCause(input logic [6:0] v);
		firstCause = v & (~v + 7'h01);
	endfunction

	reset_source_pkg::state_t state;
	reset_source_pkg::state_t next_state;

	logic       monSelect;
	logic       mcdEnable;
	logic       cmpEnable;
	logic       swForce;
	logic [6:0] pendEvt;
	logic [6:0] captured;
	logic [6:0] flags;
	logic [7:0] mcdCnt;
	logic [7:0] holdCnt;
	logic [3:0] divCnt;

	// bus decode
	wire        selMon   = paddr == reset_source_pkg::MON_ADDR;
	wire        selSrc   = paddr == reset_source_pkg::SRC_ADDR;
	wire        accept   = psel & penable & pready;
	wire        wrMon    = accept & pwrite & selMon;
	wire        wrSrc    = accept & pwrite & selSrc;
	wire        next_rdy = psel & penable & ~pready;

	// read data: unused monitor bits and bit 7 of source read zero
	wire [7:0]  monRead  = {monitorOn, supplyLevel, 6'h00};
	wire [7:0]  srcRead  = {1'b0, flags};
	wire [7:0]  rdByte   = selMon ? monRead : (selSrc ? srcRead : 8'h00);

	// level causes stay as long as their source holds them
	// own pin drive is masked, else a supply reset would hold itself
	// forever through the low level it puts on the pin
	wire        pinLvl   = ~rstPinN & ~rstPinOe;
	wire        supLvl   = monitorOn & monSelect & ~supplyLevel;
	wire        cmpLvl   = cmpEnable & ~comparatorOut;
	wire [6:0]  levels   = {1'b0, cmpLvl, 3'h0, supLvl, pinLvl};

	// one-shot timeout and event causes
	wire        mcdTrip  = mcdEnable &
		(mcdCnt == 8'(reset_source_pkg::MCD_CYC));
	wire        memTrip  = codeAccess & (codeAddr > CODE_LIMIT);
	wire        wdtTrip  = watchdogExpire & watchdogEnable;
	wire        running  = state == reset_source_pkg::ST_RUN;
	wire [6:0]  events   = running ?
		{memTrip, 1'b0, swForce, wdtTrip, mcdTrip, 2'b00} : 7'h00;
	wire [6:0]  causes   = pendEvt | levels;
	wire        anyCause = |causes;
	wire        holdDone = holdCnt >=
		8'(reset_source_pkg::HOLD_CYC - 1);
	wire        leaving  = ~running & holdDone & ~|levels;
	wire        entering = running & anyCause;
	wire        divWrap  = divCnt == 4'(reset_source_pkg::WD_DIV - 1);

	// sequencer next state
	always_comb begin
		case (state)
			reset_source_pkg::ST_RUN:
				next_state = anyCause ? reset_source_pkg::ST_HOLD
					: reset_source_pkg::ST_RUN;
			reset_source_pkg::ST_HOLD:
				next_state = leaving ? reset_source_pkg::ST_RUN
					: reset_source_pkg::ST_HOLD;
			default:
				next_state = reset_source_pkg::ST_HOLD;
		endcase
	end

	// sequencer state and cause capture
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state    <= reset_source_pkg::ST_RUN;
			captured <= reset_source_pkg::NO_CAUSE;
			holdCnt  <= 8'h00;
		end else begin
			state <= next_state;
			if (entering) begin
				captured <= firstCause(causes);
			end
			if (running) begin
				holdCnt <= 8'h00;
			end else if (!holdDone) begin
				holdCnt <= holdCnt + 8'h01;
			end
		end
	end

	// event latches, a new event wins over the clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pendEvt <= reset_source_pkg::NO_CAUSE;
		end else begin
			pendEvt <= (entering ? 7'h00 : pendEvt) | events;
		end
	end

	// core reset and pin drive; only supply resets pull the pin
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			coreReset <= 1'b0;
			rstPinOe  <= 1'b0;
			rstPinOut <= 1'b0;
		end else begin
			coreReset <= next_state == reset_source_pkg::ST_HOLD;
			rstPinOe  <= (next_state == reset_source_pkg::ST_HOLD) &
				(entering ? firstCause(causes)
				: captured) == 7'h02;
			rstPinOut <= 1'b0;
		end
	end

	// cause flags are written once, on leaving reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flags <= reset_source_pkg::FLAGS_RST;
		end else if (leaving) begin
			flags <= captured;
		end
	end

	// monitor enable survives every reset except power-on
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			monitorOn <= reset_source_pkg::MON_EN_RST;
		end else if (wrMon) begin
			monitorOn <= pwdata[reset_source_pkg::MON_EN_BIT];
		end
	end

	// reset source controls written through the flag bits
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			monSelect <= 1'b0;
			mcdEnable <= 1'b0;
			cmpEnable <= 1'b0;
			swForce   <= 1'b0;
		end else begin
			swForce <= wrSrc & pwdata[reset_source_pkg::F_SW];
			if (wrSrc) begin
				monSelect <= pwdata[reset_source_pkg::F_PWR];
				mcdEnable <= pwdata[reset_source_pkg::F_MCD];
				cmpEnable <= pwdata[reset_source_pkg::F_CMP];
			end
		end
	end

	// missing clock one-shot, retriggered by each core clock tick
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mcdCnt <= 8'h00;
		end else if (coreClkTick || !running || !mcdEnable) begin
			mcdCnt <= 8'h00;
		end else if (!mcdTrip) begin
			mcdCnt <= mcdCnt + 8'h01;
		end
	end

	// watchdog enable and its clock over twelve tick
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			watchdogEnable <= 1'b1;
			divCnt         <= 4'h0;
			watchdogTick   <= 1'b0;
		end else begin
			if (leaving) begin
				watchdogEnable <= 1'b1;
			end else if (watchdogStop) begin
				watchdogEnable <= 1'b0;
			end
			divCnt       <= divWrap ? 4'h0 : divCnt + 4'h1;
			watchdogTick <= divWrap & watchdogEnable & running;
		end
	end

	// apb slave, one wait state, unmapped answers with error
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= next_rdy;
			pslverr <= next_rdy & ~selMon & ~selSrc;
			if (next_rdy && !pwrite) begin
				prdata <= {24'h00_0000, rdByte};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence monWrite;
		wrMon;
	endsequence

	sequence swWrite;
		wrSrc && pwdata[reset_source_pkg::F_SW];
	endsequence

	sequence pinHeld;
		!rstPinN && running;
	endsequence

	mon_enable_a: assert property (
		monWrite |=> monitorOn ==
			$past(pwdata[reset_source_pkg::MON_EN_BIT]))
		else $error("monitor enable did not follow write");

	supply_gate_a: assert property (
		entering && firstCause(causes) == 7'h02 |-> monSelect)
		else $error("supply reset without source select");

	status_live_a: assert property (
		next_rdy && !pwrite && selMon |=>
			prdata[reset_source_pkg::MON_ST_BIT] == $past(supplyLevel))
		else $error("supply status not live");

	mon_unused_a: assert property (
		pready && selMon && !pwrite |-> prdata[5:0] == 6'h00)
		else $error("unused monitor bits not zero");

	pin_reset_a: assert property (
		pinHeld |=> coreReset ##1 coreReset)
		else $error("pin low did not reset");

	pin_quiet_a: assert property (
		rstPinOe |-> captured == 7'h02 || $past(entering))
		else $error("pin driven by internal reset");

	sw_force_a: assert property (
		swWrite |-> ##[1:3] coreReset)
		else $error("software reset not forced");

	flag_single_a: assert property (
		$rose(running) |-> $onehot0(flags) && flags == $past(captured))
		else $error("flags not one cause");

	wdt_enable_a: assert property (
		$rose(running) |-> watchdogEnable)
		else $error("watchdog not enabled after reset");

	// latched events reach the core two edges after they are seen
	sequence evtEnter;
		##2 coreReset;
	endsequence

	// once raised, the core reset is checked for nine cycles, one short of the ten-cycle hold time
	sequence holdMin;
		coreReset [*8] ##1 coreReset;
	endsequence

	wdt_reset_a: assert property (
		running && wdtTrip && !anyCause |-> evtEnter)
		else $error("watchdog expiry did not reset");

	// further event, level and control checks
	mcd_reset_a: assert property (
		running && mcdTrip && !anyCause |-> evtEnter)
		else $error("clock timeout did not reset");

	mem_reset_a: assert property (
		running && memTrip && !anyCause |-> evtEnter)
		else $error("code limit access did not reset");

	cmp_reset_a: assert property (
		running && cmpLvl |=> coreReset)
		else $error("comparator low did not reset");

	hold_time_a: assert property (
		$rose(coreReset) |-> holdMin)
		else $error("core reset released too early");

	mcd_enable_a: assert property (
		wrSrc |=> mcdEnable == $past(pwdata[reset_source_pkg::F_MCD]))
		else $error("clock detector enable not written");

	cmp_enable_a: assert property (
		wrSrc |=> cmpEnable == $past(pwdata[reset_source_pkg::F_CMP]))
		else $error("comparator enable not written");

	mon_keep_a: assert property (
		!wrMon |=> $stable(monitorOn))
		else $error("monitor enable changed without write");

	flag_stable_a: assert property (
		!leaving |=> $stable(flags))
		else $error("flags changed outside reset exit");

	wdt_tick_a: assert property (
		watchdogTick |-> $past(watchdogEnable) && $past(running))
		else $error("watchdog tick while stopped");

	// each cause flag except power follows the recorded cause on exit
	pin_flag_a: assert property (
		leaving |=> flags[reset_source_pkg::F_PIN] ==
			$past(captured[reset_source_pkg::F_PIN]))
		else $error("pin flag wrong after reset");

	mcd_flag_a: assert property (
		leaving |=> flags[reset_source_pkg::F_MCD] ==
			$past(captured[reset_source_pkg::F_MCD]))
		else $error("clock loss flag wrong after reset");

	wdt_flag_a: assert property (
		leaving |=> flags[reset_source_pkg::F_WDT] ==
			$past(captured[reset_source_pkg::F_WDT]))
		else $error("watchdog flag wrong after reset");

	sw_flag_a: assert property (
		leaving |=> flags[reset_source_pkg::F_SW] ==
			$past(captured[reset_source_pkg::F_SW]))
		else $error("software flag wrong after reset");

	cmp_flag_a: assert property (
		leaving |=> flags[reset_source_pkg::F_CMP] ==
			$past(captured[reset_source_pkg::F_CMP]))
		else $error("comparator flag wrong after reset");

	mem_flag_a: assert property (
		leaving |=> flags[reset_source_pkg::F_MEM] ==
			$past(captured[reset_source_pkg::F_MEM]))
		else $error("memory error flag wrong after reset");

endmodule

// ===== tb/reset_pin_driver.sv
module reset_pin_driver (
	input  wire logic sys_clk,
	input  wire logic pullLow,
	input  wire logic rstPinOut,
	input  wire logic rstPinOe,
	output logic      rstPinN
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hold;
	// external circuit pulls the pin low on request
	always_ff @(posedge sys_clk) begin
		hold <= pullLow;
	end
	// wire level: pull-up unless either party pulls low
	assign rstPinN = !(hold || (rstPinOe && !rstPinOut));
endmodule

// ===== tb/tb_top.sv
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
	n_errors++; $display("FAIL %s exp %h got %h", n, e, s); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 0;
	logic        rst = 1;
	logic [11:0] paddr = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        lastErr;
	logic        rstPinN;
	logic        rstPinOut;
	logic        rstPinOe;
	logic        pullLow = 0;
	logic        supplyLevel = 1;
	logic        comparatorOut = 1;
	logic        coreClkTick = 1;
	logic        watchdogExpire = 0;
	logic        codeAccess = 0;
	logic [15:0] codeAddr = 0;
	logic        monitorOn;
	logic        coreReset;
	logic        watchdogEnable;
	logic        watchdogStop = 0;
	logic        watchdogTick;
	int          ticks = 0;
	logic [7:0]  q;
	int          n_errors = 0;
	int          compares = 0;
	int          cycles = 0;
	localparam logic [11:0] MON = reset_source_pkg::MON_ADDR;
	localparam logic [11:0] SRC = reset_source_pkg::SRC_ADDR;
	localparam logic [15:0] LIM = reset_source_pkg::CODE_LIMIT;
	always #4 sys_clk = ~sys_clk;
	reset_pin_driver pin (.sys_clk(sys_clk), .pullLow(pullLow),
		.rstPinOut(rstPinOut), .rstPinOe(rstPinOe), .rstPinN(rstPinN));
	reset_source_controller dut (.sys_clk(sys_clk), .rst(rst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rstPinN(rstPinN), .rstPinOut(rstPinOut),
		.rstPinOe(rstPinOe), .supplyLevel(supplyLevel),
		.comparatorOut(comparatorOut), .coreClkTick(coreClkTick),
		.watchdogExpire(watchdogExpire), .watchdogStop(watchdogStop),
		.codeAccess(codeAccess), .codeAddr(codeAddr),
		.monitorOn(monitorOn), .coreReset(coreReset),
		.watchdogEnable(watchdogEnable), .watchdogTick(watchdogTick));
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [7:0] d, output logic [7:0] r);
		@(posedge sys_clk);
		psel <= 1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h00_0000, d};
		@(posedge sys_clk);
		penable <= 1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		r = prdata[7:0];
		lastErr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] r;
		apb(a, 1'b1, d, r);
	endtask
	task automatic wait_on();
		int i;
		for (i = 0; i < 200 && coreReset !== 1'b1; i++) @(posedge sys_clk);
		`CHK("reset on", 1'b1, coreReset)
	endtask
	// wait for release, then read the recorded cause
	task automatic wait_off(input logic [7:0] f);
		int i;
		for (i = 0; i < 200 && coreReset !== 1'b0; i++) @(posedge sys_clk);
		apb(SRC, 1'b0, 8'h00, q);
		`CHK("flags", f, q)
		`CHK("wd on", 1'b1, watchdogEnable)
	endtask
	task automatic code(input logic [15:0] a);
		@(posedge sys_clk);
		codeAccess <= 1;
		codeAddr <= a;
		@(posedge sys_clk);
		codeAccess <= 0;
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 0;
		repeat (30) begin
			@(posedge sys_clk);
			ticks += int'(watchdogTick);
		end
		`CHK("wd ticks", 2, ticks)
		apb(MON, 1'b0, 8'h00, q);
		`CHK("mon rd", 8'hC0, q)
		apb(SRC, 1'b0, 8'h00, q);
		`CHK("src rd", 8'h02, q)
		apb(12'h000, 1'b0, 8'h00, q);
		`CHK("unmapped", 1'b1, lastErr)
		wr(MON, 8'h3F);
		supplyLevel <= 0;
		apb(MON, 1'b0, 8'h00, q);
		`CHK("mon off", 8'h00, q)
		wr(SRC, 8'h02);
		repeat (20) @(posedge sys_clk);
		`CHK("no mon rst", 1'b0, coreReset)
		wr(MON, 8'h80);
		wait_on();
		`CHK("pin drv", 1'b1, rstPinOe)
		`CHK("pin out", 1'b0, rstPinOut)
		supplyLevel <= 1;
		wait_off(8'h02);
		wr(MON, 8'h00);
		watchdogStop <= 1;
		@(posedge sys_clk);
		watchdogStop <= 0;
		@(posedge sys_clk);
		`CHK("wd off", 1'b0, watchdogEnable)
		wr(SRC, 8'h10);
		wait_on();
		`CHK("pin free", 1'b0, rstPinOe)
		wait_off(8'h10);
		`CHK("mon kept", 1'b0, monitorOn)
		pullLow <= 1;
		wait_on();
		repeat (15) @(posedge sys_clk);
		pullLow <= 0;
		wait_off(8'h01);
		@(posedge sys_clk);
		watchdogExpire <= 1;
		@(posedge sys_clk);
		watchdogExpire <= 0;
		wait_on();
		wait_off(8'h08);
		code(LIM);
		repeat (5) @(posedge sys_clk);
		`CHK("at limit", 1'b0, coreReset)
		code(LIM + 16'h0001);
		wait_on();
		wait_off(8'h40);
		wr(SRC, 8'h20);
		comparatorOut <= 0;
		wait_on();
		repeat (15) @(posedge sys_clk);
		comparatorOut <= 1;
		wait_off(8'h20);
		wr(SRC, 8'h04);
		coreClkTick <= 0;
		wait_on();
		coreClkTick <= 1;
		wait_off(8'h04);
		print_verdict();
	end
endmodule
